//--- design/dcs_consts.svh
// Purpose: Constants of the dual codec serial compander
// Assumes: 100 MHz system clock drives all logic
// Notes: Offsets, bit positions, reset values and counts
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// ****************************************************************
// Port offsets
// ****************************************************************
`define DCS_PORT_LOW 1'h0
`define DCS_PORT_HIGH 1'h1

// ****************************************************************
// Low half bit positions
// ****************************************************************
`define DCS_B_FLAGS_LSB 0
`define DCS_B_MASK_LSB 4
`define DCS_B_PORT1_CFG 8
`define DCS_B_EXT_FRAME 9
`define DCS_B_XF 10
`define DCS_B_SERIAL_EN 11
`define DCS_B_ENC_EN 12
`define DCS_B_DEC_EN 13
`define DCS_B_LAW 14
`define DCS_B_SCLK_IN 15

// ****************************************************************
// High half bit positions (relative to bit 16)
// ****************************************************************
`define DCS_B_MOD_LSB 0
`define DCS_B_PRE_LSB 8
`define DCS_B_FR_WIDE 12
`define DCS_B_TWOS 13

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define DCS_LOW_RESET 16'h0000
`define DCS_HIGH_RESET 16'h0000
`define DCS_FR_NARROW 4'h1
`define DCS_FR_WIDE_CYC 4'h8
`define DCS_SAMPLE_BITS 4'h8
`define DCS_MU_BIAS 13'h0021
`define DCS_MU_MAX 13'h1fff

// Prescale codes and half ratios (ratio / 2)
`define DCS_PRE_C0 4'h0
`define DCS_PRE_C1 4'h1
`define DCS_PRE_C2 4'h2
`define DCS_PRE_C4 4'h4
`define DCS_PRE_C8 4'h8
`define DCS_PRE_C9 4'h9
`define DCS_PRE_CA 4'ha
`define DCS_PRE_CC 4'hc
`define DCS_HALF_32 5'h10
`define DCS_HALF_28 5'h0e
`define DCS_HALF_24 5'h0c
`define DCS_HALF_20 5'h0a
`define DCS_HALF_16 5'h08
`define DCS_HALF_14 5'h07
`define DCS_HALF_12 5'h06
`define DCS_HALF_10 5'h05

`endif

//--- design/dcs_pkg.sv
// Purpose: Types of the dual codec serial compander
// Assumes: Nothing beyond the constants header
// Notes: Shift engine states are Gray coded
package dcs_pkg;
	typedef enum logic [1:0] {
		DCS_ST_IDLE = 2'b00,
		DCS_ST_SHIFT = 2'b01,
		DCS_ST_LAST = 2'b11
	} dcs_shift_state_t;

	typedef enum logic {
		DCS_LAW_MU = 1'b0,
		DCS_LAW_A = 1'b1
	} dcs_law_t;
endpackage

//--- design/dcs_compander.sv
// Purpose: Combinational mu-law and A-law encoder and decoder
// Assumes: 14-bit linear input, 8-bit log code
// Notes: Two's-complement mode biases mu-law internally
`timescale 1ns/1ps
`default_nettype none
`include "dcs_consts.svh"

module dcs_compander (
	input wire dcs_pkg::dcs_law_t law_i,
	input wire logic twos_i,
	input wire logic [13:0] enc_in_i,
	output logic [7:0] enc_o,
	input wire logic [7:0] dec_in_i,
	output logic [15:0] dec_o
);
	import dcs_pkg::*;

	logic neg;
	logic [13:0] abs_v;
	logic [12:0] mag;
	logic [12:0] mu_mag;
	logic [2:0] seg;
	logic [3:0] mant;
	logic [7:0] dcode;
	logic [2:0] dseg;
	logic [3:0] dmant;
	logic [13:0] lin;
	logic [13:0] sm_out;

	// ****************************************************************
	// Encoder
	// ****************************************************************
	always_comb begin
		neg = enc_in_i[13];
		abs_v = twos_i ? (neg ? 14'(-enc_in_i) : enc_in_i)
			: {1'b0, enc_in_i[12:0]};
		mag = abs_v[13] ? `DCS_MU_MAX : abs_v[12:0];
		seg = 3'h0;
		mant = 4'h0;
		mu_mag = mag;
		if (twos_i && law_i == DCS_LAW_MU) begin
			mu_mag = (mag > 13'(`DCS_MU_MAX - `DCS_MU_BIAS)) ? `DCS_MU_MAX
				: 13'(mag + `DCS_MU_BIAS);
		end
		if (law_i == DCS_LAW_MU) begin
			for (int i = 5; i <= 12; i++) begin
				if (mu_mag[i]) begin
					seg = 3'(i - 5);
				end
			end
			mant = 4'(mu_mag >> (4'(seg) + 4'h1));
			enc_o = {~neg, ~seg, ~mant}; // R13
		end else begin
			if (mag[12]) begin
				mag = 13'h0fff;
			end
			for (int i = 5; i <= 11; i++) begin
				if (mag[i]) begin
					seg = 3'(i - 4);
				end
			end
			mant = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
			enc_o = {~neg, seg, mant} ^ 8'h55; // R13
		end
	end

	// ****************************************************************
	// Decoder
	// ****************************************************************
	always_comb begin
		dcode = (law_i == DCS_LAW_MU) ? ~dec_in_i : (dec_in_i ^ 8'h55);
		dseg = dcode[6:4];
		dmant = dcode[3:0];
		if (law_i == DCS_LAW_MU) begin
			lin = 14'(((({10'h0, dmant} << 1) + 14'h0021) << dseg)
				- 14'h0021); // R15
		end else if (dseg == 3'h0) begin
			lin = 14'(({10'h0, dmant} << 1) + 14'h0001);
		end else begin
			lin = 14'((({10'h0, dmant} << 1) + 14'h0021)
				<< (dseg - 3'h1)); // R15
		end
		// Code bit 7 set means positive in both laws
		sm_out = {~dec_in_i[7], lin[12:0]};
		if (twos_i) begin
			dec_o = dec_in_i[7] ? {2'b00, lin} : 16'(-{2'b00, lin}); // R12
		end else begin
			dec_o = {2'b00, sm_out};
		end
	end
endmodule // dcs_compander
`default_nettype wire

//--- design/dcs_top.sv
// Purpose: Dual codec serial port with prescaler, frame counter, compander
// Assumes: Port bus and pins synchronous to clk_sys_i
// Notes: Read data appears one cycle after io_rd_i
// Operation
// R1: 32-bit control register; low 16 bits on port 0 steer irq, serial, companding.
// R2: Port 1 reaches high control bits, serial channels or compander by configuration.
// R3: Four maskable interrupt sources: external, internal frame, tx frame, rx frame.
// R4: Masked interrupt flags stay readable for polling.
// R5: Two 8-bit receive and two 8-bit transmit registers on port 1.
// R6: Serial shifting MSB first; internal or external framing selectable.
// R7: With serial clock as input, outside party drives it and timing follows it.
// R8: With serial clock as output, system clock divided by prescale field.
// R9: Internal frame pulse made by dividing serial clock with frame modulus.
// R10: Law select bit picks mu-law or A-law.
// R11: Software biases sign-magnitude mu-law samples by 33; none in two's-complement.
// R12: Reset gives sign-magnitude; bit 29 selects two's-complement.
// R13: Serial encoder compresses linear sample to 8-bit sign-magnitude log code.
// R14: Encoded byte loads transmit register, shifts out on next active frame.
// R15: Decoder expands 8-bit log code from receive register to linear.
// R16: Parallel mode disables serial registers; port 1 goes via compander when bit 12 or 13 is set, else the word is stored raw.
// R17: Parallel encode: 14-bit write encoded, result read back from port 1.
// R18: Parallel decode: 8-bit write expanded, result on next port 1 read.
// R19: Software leaves one instruction between port 1 write and read.
// R20: Frame rate is serial clock over modulus plus 2.
// R21: Prescale codes divide by 32,28,24,20,16,14,12,10.
// R22: Bit 11 clear selects parallel companding; set selects serial mode.
// R23: Writing 1 to flag bits 0-3 clears them; bits 4-7 are masks.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_consts.svh"

module dcs_top (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic io_port_i,
	input wire logic [15:0] io_wdata_i,
	output logic [15:0] io_rdata_o,
	output logic io_rvalid_o,
	output logic irq_o,
	input wire logic external_interrupt_in_i,
	input wire logic external_transmit_frame_i,
	input wire logic external_receive_frame_i,
	input wire logic [1:0] serial_receive_lines_i,
	output logic [1:0] serial_transmit_lines_o,
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_o,
	output logic internal_frame_pulse_o,
	output logic external_flag_output_o
);
	import dcs_pkg::*;

	logic [15:0] lo_q;
	logic [15:0] hi_q;
	logic [3:0] flag_q;
	logic [3:0] src_prev_q;
	logic [3:0] src_now;
	logic [4:0] pre_cnt_q;
	logic [4:0] pre_half;
	logic sclk_int_q;
	logic sclk_in_q;
	logic sclk_in_prev_q;
	logic s_rise;
	logic s_fall;
	logic [8:0] fcnt_q;
	logic [3:0] fr_left_q;
	logic [8:0] fcnt_d;
	logic tx_frame;
	logic rx_frame;
	logic tx_fprev_q;
	logic rx_fprev_q;
	logic [7:0] tx_reg_q [2];
	logic [7:0] rx_reg_q [2];
	logic [7:0] tx_sh_q [2];
	logic [7:0] rx_sh_q [2];
	logic [1:0] txo_q;
	dcs_shift_state_t tx_st_q;
	logic [3:0] tx_cnt_q;
	logic rx_busy_q;
	logic [3:0] rx_cnt_q;
	logic wr_ch_q;
	logic rd_ch_q;
	logic [15:0] par_q;
	logic [7:0] enc;
	logic [7:0] dec_in;
	logic [15:0] dec;
	logic wr0;
	logic wr1;
	logic rd1;
	logic p1_regs;
	logic ser_mode;

	assign wr0 = io_wr_i && io_port_i == `DCS_PORT_LOW;
	assign wr1 = io_wr_i && io_port_i == `DCS_PORT_HIGH;
	assign rd1 = io_rd_i && io_port_i == `DCS_PORT_HIGH;
	assign p1_regs = lo_q[`DCS_B_PORT1_CFG];
	assign ser_mode = lo_q[`DCS_B_SERIAL_EN];

	// ****************************************************************
	// Compander
	// ****************************************************************
	assign dec_in = ser_mode ? rx_reg_q[rd_ch_q] : io_wdata_i[7:0];

	dcs_compander u_comp (
		.law_i(dcs_law_t'(lo_q[`DCS_B_LAW])), // R10
		.twos_i(hi_q[`DCS_B_TWOS]), // R12
		.enc_in_i(io_wdata_i[13:0]),
		.enc_o(enc),
		.dec_in_i(dec_in),
		.dec_o(dec)
	);

	// ****************************************************************
	// Control register
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lo_q <= `DCS_LOW_RESET;
			hi_q <= `DCS_HIGH_RESET; // R12
		end else begin
			if (wr0) begin
				lo_q <= {io_wdata_i[15:4], 4'h0}; // R1
			end
			if (wr1 && p1_regs) begin
				hi_q <= io_wdata_i; // R2
			end
		end
	end

	// ****************************************************************
	// Interrupt flags
	// ****************************************************************
	assign src_now = {internal_frame_pulse_o, external_transmit_frame_i,
		external_receive_frame_i, external_interrupt_in_i}; // R3

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			src_prev_q <= 4'h0;
			flag_q <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			src_prev_q <= src_now;
			// Set beats a simultaneous clear
			flag_q <= (flag_q & ~(wr0 ? io_wdata_i[3:0] : 4'h0))
				| (src_now & ~src_prev_q); // R23 R4
			irq_o <= |(flag_q & lo_q[7:4]); // R3
		end
	end

	// ****************************************************************
	// Serial clock
	// ****************************************************************
	always_comb begin
		case (hi_q[11:8])
			`DCS_PRE_C1: pre_half = `DCS_HALF_28;
			`DCS_PRE_C2: pre_half = `DCS_HALF_24;
			`DCS_PRE_C4: pre_half = `DCS_HALF_20;
			`DCS_PRE_C8: pre_half = `DCS_HALF_16;
			`DCS_PRE_C9: pre_half = `DCS_HALF_14;
			`DCS_PRE_CA: pre_half = `DCS_HALF_12;
			`DCS_PRE_CC: pre_half = `DCS_HALF_10;
			default: pre_half = `DCS_HALF_32;
		endcase // R21
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_cnt_q <= 5'h00;
			sclk_int_q <= 1'b0;
			sclk_in_q <= 1'b0;
			sclk_in_prev_q <= 1'b0;
			sclk_o <= 1'b0;
			sclk_oe_o <= 1'b0;
		end else begin
			sclk_in_q <= sclk_i;
			sclk_in_prev_q <= sclk_in_q;
			if (pre_cnt_q >= 5'(pre_half - 5'h01)) begin
				pre_cnt_q <= 5'h00;
				sclk_int_q <= ~sclk_int_q; // R8
			end else begin
				pre_cnt_q <= pre_cnt_q + 5'h01;
			end
			sclk_o <= sclk_int_q;
			sclk_oe_o <= ~lo_q[`DCS_B_SCLK_IN]; // R8
		end
	end

	always_comb begin
		if (lo_q[`DCS_B_SCLK_IN]) begin
			s_rise = sclk_in_q && !sclk_in_prev_q; // R7
			s_fall = !sclk_in_q && sclk_in_prev_q;
		end else begin
			s_rise = !sclk_int_q && pre_cnt_q >= 5'(pre_half - 5'h01);
			s_fall = sclk_int_q && pre_cnt_q >= 5'(pre_half - 5'h01);
		end
	end

	// ****************************************************************
	// Frame counter
	// ****************************************************************
	assign fcnt_d = (fcnt_q >= {1'b0, hi_q[7:0]} + 9'h001) ? 9'h000
		: fcnt_q + 9'h001; // R20

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fcnt_q <= 9'h000;
			fr_left_q <= 4'h0;
			internal_frame_pulse_o <= 1'b0;
		end else if (s_rise) begin
			fcnt_q <= fcnt_d; // R9
			if (fcnt_d == 9'h000) begin
				fr_left_q <= hi_q[`DCS_B_FR_WIDE] ? `DCS_FR_WIDE_CYC
					: `DCS_FR_NARROW;
				internal_frame_pulse_o <= 1'b1;
			end else begin
				fr_left_q <= (fr_left_q != 4'h0) ? fr_left_q - 4'h1 : 4'h0;
				internal_frame_pulse_o <= fr_left_q > 4'h1;
			end
		end
	end

	// ****************************************************************
	// Serial shifting
	// ****************************************************************
	assign tx_frame = lo_q[`DCS_B_EXT_FRAME] ? external_transmit_frame_i
		: internal_frame_pulse_o; // R6
	assign rx_frame = lo_q[`DCS_B_EXT_FRAME] ? external_receive_frame_i
		: internal_frame_pulse_o; // R6

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_fprev_q <= 1'b0;
			tx_st_q <= DCS_ST_IDLE;
			tx_cnt_q <= 4'h0;
			txo_q <= 2'b00;
			tx_sh_q <= '{8'h00, 8'h00};
		end else if (s_rise) begin
			tx_fprev_q <= tx_frame;
			case (tx_st_q)
				DCS_ST_IDLE: begin
					if (ser_mode && tx_frame && !tx_fprev_q) begin
						tx_sh_q <= tx_reg_q; // R14
						txo_q <= {tx_reg_q[1][7], tx_reg_q[0][7]};
						tx_cnt_q <= `DCS_SAMPLE_BITS - 4'h1;
						tx_st_q <= DCS_ST_SHIFT;
					end
				end
				DCS_ST_SHIFT: begin
					for (int c = 0; c < 2; c++) begin
						tx_sh_q[c] <= {tx_sh_q[c][6:0], 1'b0};
						txo_q[c] <= tx_sh_q[c][6]; // R6
					end
					tx_cnt_q <= tx_cnt_q - 4'h1;
					if (tx_cnt_q == 4'h1) begin
						tx_st_q <= DCS_ST_LAST;
					end
				end
				DCS_ST_LAST: begin
					txo_q <= 2'b00;
					tx_st_q <= DCS_ST_IDLE;
				end
				default: tx_st_q <= DCS_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_fprev_q <= 1'b0;
			rx_busy_q <= 1'b0;
			rx_cnt_q <= 4'h0;
			rx_sh_q <= '{8'h00, 8'h00};
			rx_reg_q <= '{8'h00, 8'h00};
		end else begin
			if (s_rise) begin
				rx_fprev_q <= rx_frame;
				if (ser_mode && rx_frame && !rx_fprev_q && !rx_busy_q) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q <= 4'h0;
				end
			end
			if (s_fall && rx_busy_q) begin
				for (int c = 0; c < 2; c++) begin
					rx_sh_q[c] <= {rx_sh_q[c][6:0], serial_receive_lines_i[c]};
				end
				rx_cnt_q <= rx_cnt_q + 4'h1;
				if (rx_cnt_q == `DCS_SAMPLE_BITS - 4'h1) begin
					rx_busy_q <= 1'b0;
					for (int c = 0; c < 2; c++) begin
						rx_reg_q[c] <= {rx_sh_q[c][6:0],
							serial_receive_lines_i[c]}; // R5
					end
				end
			end
		end
	end

	// ****************************************************************
	// Port 1 data path
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_reg_q <= '{8'h00, 8'h00};
			wr_ch_q <= 1'b0;
			par_q <= 16'h0000;
		end else if (wr1 && !p1_regs) begin
			if (ser_mode) begin
				tx_reg_q[wr_ch_q] <= lo_q[`DCS_B_ENC_EN] ? enc
					: io_wdata_i[7:0]; // R13 R22
				wr_ch_q <= ~wr_ch_q;
			end else if (lo_q[`DCS_B_ENC_EN]) begin
				par_q <= {8'h00, enc}; // R17 R16
			end else if (lo_q[`DCS_B_DEC_EN]) begin
				par_q <= dec; // R18
			end else begin
				par_q <= io_wdata_i;
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_rdata_o <= 16'h0000;
			io_rvalid_o <= 1'b0;
			rd_ch_q <= 1'b0;
			serial_transmit_lines_o <= 2'b00;
			external_flag_output_o <= 1'b0;
		end else begin
			io_rvalid_o <= io_rd_i;
			serial_transmit_lines_o <= txo_q;
			external_flag_output_o <= lo_q[`DCS_B_XF];
			if (io_rd_i && !rd1) begin
				io_rdata_o <= {lo_q[15:4], flag_q}; // R4 R1
			end else if (rd1 && p1_regs) begin
				io_rdata_o <= hi_q; // R2
			end else if (rd1 && ser_mode) begin
				io_rdata_o <= lo_q[`DCS_B_DEC_EN] ? dec
					: {8'h00, rx_reg_q[rd_ch_q]}; // R15 R5
				rd_ch_q <= ~rd_ch_q;
			end else if (rd1) begin
				io_rdata_o <= par_q; // R16
			end
		end
	end
endmodule // dcs_top
`default_nettype wire

//--- test/dcs_codec.sv
// Purpose: Model of the two codecs on the serial side
// Assumes: Device takes the serial clock as an input
// Notes: Clock runs nine cycles, frame high for the first only; released data is inverted
`timescale 1ns/1ps
`default_nettype none
module dcs_codec (
	output logic sclk_o,
	output logic frame_o,
	output logic [1:0] rx_o,
	input wire logic [1:0] tx_i
);
	logic [7:0] got0;
	logic [7:0] got1;
	initial begin
		sclk_o = 1'b0;
		frame_o = 1'b0;
		rx_o = 2'b01;
		got0 = 8'h00;
		got1 = 8'h00;
	end
	// ****************************************
	// One frame, both channels
	// ****************************************
	task automatic run(input logic [7:0] b0, input logic [7:0] b1);
		int i;
		#2;
		frame_o = 1'b1;
		#100;
		for (i = 0; i < 9; i++) begin
			sclk_o = 1'b1;
			if (i < 8) begin
				rx_o = {b1[7 - i], b0[7 - i]};
			end else begin
				rx_o = ~rx_o;
			end
			#100;
			sclk_o = 1'b0;
			frame_o = 1'b0;
			if (i < 8) begin
				got0 = {got0[6:0], tx_i[0]};
				got1 = {got1[6:0], tx_i[1]};
			end
			#100;
		end
	endtask
endmodule // dcs_codec
`default_nettype wire

//--- test/dcs_properties.sv
// Purpose: Concurrent checks on the dcs_top ports
// Assumes: One clock domain, reset active low
// Notes: Bound to every dcs_top instance
`timescale 1ns/1ps
`default_nettype none
module dcs_checker (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic io_port_i,
	input wire logic [15:0] io_wdata_i,
	input wire logic [15:0] io_rdata_o,
	input wire logic io_rvalid_o,
	input wire logic irq_o,
	input wire logic [1:0] serial_transmit_lines_o,
	input wire logic sclk_o,
	input wire logic sclk_oe_o,
	input wire logic internal_frame_pulse_o
);
	logic w0;
	logic ser_q;
	assign w0 = io_wr_i && !io_port_i;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	// ****************************************
	// Serial enable shadow and checks
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ser_q <= 1'b0;
		end else if (w0) begin
			ser_q <= io_wdata_i[11];
		end
	end
	chk_read_answers: assert property (io_rd_i |=> io_rvalid_o)
		else $error("read not answered");
	chk_valid_cause: assert property (io_rvalid_o |-> $past(io_rd_i))
		else $error("valid without read");
	chk_rdata_holds: assert property (!io_rd_i |=> $stable(io_rdata_o))
		else $error("read data moved");
	chk_mask_quiet: assert property ((w0 && io_wdata_i[7:4] == 4'h0 ##1 !w0)
		|-> ##1 !irq_o) else $error("irq with masks off");
	chk_oe_input: assert property ((w0 && io_wdata_i[15])
		|-> ##[1:2] !sclk_oe_o) else $error("clock still driven");
	chk_oe_output: assert property ((w0 && !io_wdata_i[15])
		|-> ##[1:2] sclk_oe_o) else $error("clock not driven");
	chk_tx_quiet: assert property ((!ser_q && !$past(ser_q)
		&& !$past(ser_q, 2)) |-> serial_transmit_lines_o == 2'b00)
		else $error("tx active in parallel mode");
	chk_sclk_half: assert property ($changed(sclk_o)
		|=> $stable(sclk_o)[*4]) else $error("clock half too short");
	chk_frame_ends: assert property (($rose(internal_frame_pulse_o)
		&& sclk_oe_o) |-> ##[1:300] !internal_frame_pulse_o)
		else $error("frame pulse stuck");
	chk_frame_gap: assert property (($fell(internal_frame_pulse_o)
		&& sclk_oe_o) |=> !internal_frame_pulse_o[*8])
		else $error("frame gap too short");
endmodule // dcs_checker
bind dcs_top dcs_checker u_dcs_checker (.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
	.io_port_i(io_port_i), .io_wdata_i(io_wdata_i),
	.io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .irq_o(irq_o),
	.serial_transmit_lines_o(serial_transmit_lines_o), .sclk_o(sclk_o),
	.sclk_oe_o(sclk_oe_o), .internal_frame_pulse_o(internal_frame_pulse_o));
`default_nettype wire

//--- test/dcs_top_test.sv
// Purpose: Self-checking bench for dcs_top
// Assumes: Codec model supplies clock and framing in input mode
// Notes: Prescale loop covers all eight listed codes
`timescale 1ns/1ps
`default_nettype none
module dcs_top_test;
	logic clk_sys_i = 0, rstn_i = 0, io_wr_i = 0, io_rd_i = 0;
	logic io_port_i = 0, external_interrupt_in = 0, io_rvalid_o, irq_o, sclk_o, oe, fr;
	logic sck, frm, xf;
	logic [15:0] io_wdata_i = 0, io_rdata_o, d, a;
	logic [1:0] tx, rx;
	int fail_count = 0, n_tests = 0, n, i;
	int pr[8] = '{32, 28, 24, 20, 16, 14, 12, 10};
	logic [3:0] pc[8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'ha, 4'hc};
	always #5 clk_sys_i = ~clk_sys_i;
	dcs_top u_dcs_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_port_i(io_port_i),
		.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.io_rvalid_o(io_rvalid_o), .irq_o(irq_o),
		.external_interrupt_in_i(external_interrupt_in), .external_transmit_frame_i(frm),
		.external_receive_frame_i(frm), .serial_receive_lines_i(rx),
		.serial_transmit_lines_o(tx), .sclk_i(sck), .sclk_o(sclk_o),
		.sclk_oe_o(oe), .internal_frame_pulse_o(fr),
		.external_flag_output_o(xf));
	dcs_codec u_dcs_codec (.sclk_o(sck), .frame_o(frm), .rx_o(rx),
		.tx_i(tx));
	// ****************************************
	// Bus cycles and helpers
	// ****************************************
	task automatic wr(input logic p, input logic [15:0] v);
		@(posedge clk_sys_i);
		io_wr_i <= 1'b1;
		io_port_i <= p;
		io_wdata_i <= v;
		@(posedge clk_sys_i);
		io_wr_i <= 1'b0;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic p, output logic [15:0] v);
		@(posedge clk_sys_i);
		io_rd_i <= 1'b1;
		io_port_i <= p;
		@(posedge clk_sys_i);
		io_rd_i <= 1'b0;
		#1;
		chk({15'h0, io_rvalid_o}, 16'h0001);
		v = io_rdata_o;
	endtask
	task automatic per(input logic s, output int w);
		int k, t;
		logic p, c;
		t = -1;
		w = 0;
		p = 1'b1;
		for (k = 0; k < 4000 && w == 0; k++) begin
			@(posedge clk_sys_i);
			#1;
			c = s ? fr : sclk_o;
			if (c && !p) begin
				if (t < 0) t = k;
				else w = k - t;
			end
			p = c;
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_serial;
		rd(1'b0, d);
		chk(d, 16'h0000);
		chk({15'h0, oe}, 16'h0001);
		wr(1'b0, 16'h8a00);
		wr(1'b1, 16'h00a5);
		wr(1'b1, 16'h003c);
		u_dcs_codec.run(8'h5a, 8'hc3);
		chk({8'h0, u_dcs_codec.got0}, 16'h00a5);
		chk({8'h0, u_dcs_codec.got1}, 16'h003c);
		rd(1'b1, d);
		chk({8'h0, d[7:0]}, 16'h005a);
		rd(1'b1, d);
		chk({8'h0, d[7:0]}, 16'h00c3);
		wr(1'b0, 16'hba00);
		wr(1'b1, 16'h1fff);
		wr(1'b1, 16'h3100);
		u_dcs_codec.run(8'h80, 8'h00);
		chk({8'h0, u_dcs_codec.got0}, 16'h0080);
		chk({8'h0, u_dcs_codec.got1}, 16'h000e);
		rd(1'b1, d);
		chk(d, 16'h1f5f);
		rd(1'b1, d);
		chk(d, 16'h3f5f);
		rd(1'b0, d);
		chk(d & 16'h0006, 16'h0006);
		chk({15'h0, oe}, 16'h0000);
	endtask
	task automatic t_irq;
		wr(1'b0, 16'h040f);
		rd(1'b0, d);
		chk(d & 16'h0007, 16'h0000);
		chk({15'h0, xf}, 16'h0001);
		@(posedge clk_sys_i);
		external_interrupt_in <= 1'b1;
		rd(1'b0, d);
		chk(d & 16'h0007, 16'h0001);
		chk({15'h0, irq_o}, 16'h0000);
		wr(1'b0, 16'h0010);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk({15'h0, irq_o}, 16'h0001);
		wr(1'b0, 16'h0011);
		rd(1'b0, d);
		chk(d & 16'h00f7, 16'h0010);
		chk({15'h0, irq_o}, 16'h0000);
		chk({15'h0, xf}, 16'h0000);
		@(posedge clk_sys_i);
		external_interrupt_in <= 1'b0;
	endtask
	task automatic t_par;
		wr(1'b0, 16'h0000);
		wr(1'b1, 16'h1234);
		rd(1'b1, d);
		chk(d, 16'h1234);
		wr(1'b0, 16'h1000);
		wr(1'b1, 16'h1fff);
		rd(1'b1, d);
		chk({8'h0, d[7:0]}, 16'h0080);
		wr(1'b1, 16'h3100);
		rd(1'b1, d);
		chk({8'h0, d[7:0]}, 16'h000e);
		wr(1'b1, 16'h0100);
		rd(1'b1, a);
		wr(1'b0, 16'h5000);
		wr(1'b1, 16'h0100);
		rd(1'b1, d);
		chk({15'h0, d[7:0] !== a[7:0]}, 16'h0001);
		wr(1'b0, 16'h2000);
		wr(1'b1, 16'h0080);
		rd(1'b1, d);
		chk(d, 16'h1f5f);
		wr(1'b1, 16'h0000);
		rd(1'b1, d);
		chk(d, 16'h3f5f);
	endtask
	task automatic t_high;
		wr(1'b0, 16'h0100);
		wr(1'b1, 16'ha0fe);
		rd(1'b1, d);
		chk(d, 16'ha0fe);
		wr(1'b1, 16'h2008);
		wr(1'b0, 16'h2000);
		wr(1'b1, 16'h0000);
		rd(1'b1, d);
		chk(d, 16'he0a1);
		wr(1'b0, 16'h0100);
		for (i = 0; i < 8; i++) begin
			wr(1'b1, {4'h0, pc[i], 8'h08});
			per(1'b0, n);
			chk(16'(n), 16'(pr[i]));
		end
		per(1'b1, n);
		chk(16'(n), 16'd100);
	endtask
	initial begin
		#200000;
		fail_count++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		@(posedge clk_sys_i);
		t_serial;
		t_irq;
		t_par;
		t_high;
		print_verdict;
	end
endmodule // dcs_top_test
`default_nettype wire
